// ==== logic/capcmp_pkg.sv ====
// constants for the two-channel capture/compare timer
// Overview of operation
// RL1: each channel value register is 16 bits, read/write, compared against counter
// RL2: capture edge copies counter into channel value and raises channel event
// RL3: captures only while counter runs; channels capture independently
// RL4: on match, next level moves to pin bit, second level to next level
// RL5: on compare match, reload register loads into channel value register
// RL6: channel control has three bits; upper five ignore writes, read ones, reset f8
// RL7: edge control bits 2-3 select channel 0 edge, bits 4-5 channel 1
// RL8: edge control top bits read ones, bottom bits zeros, reset c0
// RL9: capture pins sampled on falling clock edge, used for edge detection
// RL10: source holds capture pulses at least one clock period
// RL11: reset clears both channel value registers to 0000
// RL12: each channel has a 16-bit read/write reload register reset to 0000
// RL13: counter control bits 0-2 pick count clock, bit 3 runs counter
// RL14: counter control bit 4 and 5 pick capture mode per channel
// RL15: software may write the counter anytime; reads return live count
// RL16: channel control bit 0 is writable initial pin level; pin follows it
// RL17: software avoids bit read-modify-write on channel control near a match
// RL18: software sets port direction and alternate function per mode
// RL19: compare match raises the channel event shared with capture
// RL20: counter overflow wraps to zero and raises overflow event
// RL21: edge code 00 off, 01 rising, 10 falling, 11 both
// RL22: match acts once per count step, not while halted at that value
package capcmp_pkg;

  localparam int NUM_CHAN = 2;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int TICK_W = 8;

  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_COUNT = 4'h0;
  localparam logic [3:0] IDX_CHAN0_VALUE = 4'h1;
  localparam logic [3:0] IDX_CHAN1_VALUE = 4'h2;
  localparam logic [3:0] IDX_COUNTER_CONTROL = 4'h3;
  localparam logic [3:0] IDX_CAPTURE_EDGE_CONTROL = 4'h4;
  localparam logic [3:0] IDX_CHAN0_CONTROL = 4'h5;
  localparam logic [3:0] IDX_CHAN1_CONTROL = 4'h6;
  localparam logic [3:0] IDX_CHAN0_RELOAD = 4'h7;
  localparam logic [3:0] IDX_CHAN1_RELOAD = 4'h8;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int POS_PIN_OUTPUT_BIT = 0;
  localparam int POS_NEXT_LEVEL_BUFFER = 1;
  localparam int POS_SECOND_LEVEL_BUFFER = 2;
  localparam int POS_COUNT_CLOCK_SELECT = 0;
  localparam int POS_COUNTER_RUN = 3;
  localparam int POS_CHAN0_MODE_SELECT = 4;
  localparam int POS_CHAN0_EDGE_SELECT = 2;
  localparam int EDGE_FIELD_W = 2;

  // ------------------------------------------------------------
  // reset values and fixed read bits
  // ------------------------------------------------------------
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_CHAN_CONTROL = 8'hf8;
  localparam logic [7:0] RST_CAPTURE_EDGE_CONTROL = 8'hc0;
  localparam logic [7:0] RST_COUNTER_CONTROL = 8'hc0;
  localparam logic [7:0] ONES_CHAN_CONTROL = 8'hf8;
  localparam logic [7:0] ONES_CAPTURE_EDGE_CONTROL = 8'hc0;
  localparam logic [7:0] ONES_COUNTER_CONTROL = 8'hc0;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // ------------------------------------------------------------
  // edge codes
  // ------------------------------------------------------------
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage

// ==== logic/capcmp_pin_sampler.sv ====
// falling-edge sampler for the capture pins
`timescale 1ns/1ns
module capcmp_pin_sampler (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [capcmp_pkg::NUM_CHAN-1:0] pin_i,
  output logic [capcmp_pkg::NUM_CHAN-1:0] sampled_o
);

  typedef struct packed {
    logic [capcmp_pkg::NUM_CHAN-1:0] sample;
  } sampler_state_t;

  sampler_state_t state_r;
  sampler_state_t state_nxt;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (ce_i) begin
      state_nxt.sample = pin_i;
    end
  end

  // ------------------------------------------------------------
  // falling-edge register
  // ------------------------------------------------------------
  always_ff @(negedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt; // RL9
    end
  end

  assign sampled_o = state_r.sample;

endmodule

// ==== logic/capcmp_timer.sv ====
// two-channel capture/compare timer with free-running counter
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module capcmp_timer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [capcmp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [capcmp_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [capcmp_pkg::DATA_W-1:0] rdata_o,
  input wire logic [capcmp_pkg::TICK_W-1:0] count_tick_i,
  input wire logic [capcmp_pkg::NUM_CHAN-1:0] channel_pin_i,
  output logic [capcmp_pkg::NUM_CHAN-1:0] channel_pin_o,
  output logic [capcmp_pkg::NUM_CHAN-1:0] channel_pin_oe_b_o,
  output logic [capcmp_pkg::NUM_CHAN-1:0] chan_event_o,
  output logic overflow_event_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic [2:0] clk_sel;
    logic run;
    logic [1:0] mode;
    logic [1:0][1:0] edge_sel;
    logic [1:0][15:0] value;
    logic [1:0][15:0] reload;
    logic [1:0][2:0] ctl;
    logic [1:0] pin_prev;
    logic [1:0] chan_evt;
    logic ovf_evt;
    logic [15:0] rdata;
  } timer_state_t;

  timer_state_t state_r;
  timer_state_t state_nxt;

  logic [capcmp_pkg::NUM_CHAN-1:0] pin_sampled;

  // ------------------------------------------------------------
  // capture pin sampling
  // ------------------------------------------------------------
  capcmp_pin_sampler u_sampler (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .pin_i(channel_pin_i),
    .sampled_o(pin_sampled)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic tick;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] edge_hit;
  logic [1:0] match;

  always_comb begin
    tick = count_tick_i[state_r.clk_sel] & state_r.run; // RL13
  end

  // per-channel edge and match detection
  for (genvar c = 0; c < capcmp_pkg::NUM_CHAN; c++) begin : g_chan
    always_comb begin
      rise[c] = pin_sampled[c] & ~state_r.pin_prev[c];
      fall[c] = ~pin_sampled[c] & state_r.pin_prev[c];
      unique case (state_r.edge_sel[c]) // RL21
        capcmp_pkg::EDGE_OFF: edge_hit[c] = 1'b0;
        capcmp_pkg::EDGE_RISE: edge_hit[c] = rise[c];
        capcmp_pkg::EDGE_FALL: edge_hit[c] = fall[c];
        capcmp_pkg::EDGE_BOTH: edge_hit[c] = rise[c] | fall[c];
      endcase
      // one action per counter step, none while halted
      match[c] = tick & ~state_r.mode[c] & (state_r.count == state_r.value[c]); // RL1 RL22
    end
  end

  // ------------------------------------------------------------
  // read data formatting
  // ------------------------------------------------------------
  logic [7:0] counter_control_rd;
  logic [7:0] edge_control_rd;
  logic [1:0][7:0] chan_control_rd;

  always_comb begin
    counter_control_rd = capcmp_pkg::ONES_COUNTER_CONTROL;
    counter_control_rd[capcmp_pkg::POS_COUNT_CLOCK_SELECT +: 3] = state_r.clk_sel;
    counter_control_rd[capcmp_pkg::POS_COUNTER_RUN] = state_r.run;
    counter_control_rd[capcmp_pkg::POS_CHAN0_MODE_SELECT +: 2] = state_r.mode;
    edge_control_rd = capcmp_pkg::ONES_CAPTURE_EDGE_CONTROL; // RL8
    edge_control_rd[capcmp_pkg::POS_CHAN0_EDGE_SELECT +: 4] = state_r.edge_sel; // RL7
    for (int c = 0; c < capcmp_pkg::NUM_CHAN; c++) begin
      chan_control_rd[c] = capcmp_pkg::ONES_CHAN_CONTROL; // RL6
      chan_control_rd[c][2:0] = state_r.ctl[c];
    end
  end

  logic [15:0] rd_mux;

  always_comb begin
    unique case (addr_i)
      capcmp_pkg::IDX_COUNT: rd_mux = state_r.count; // RL15
      capcmp_pkg::IDX_CHAN0_VALUE: rd_mux = state_r.value[0];
      capcmp_pkg::IDX_CHAN1_VALUE: rd_mux = state_r.value[1];
      capcmp_pkg::IDX_COUNTER_CONTROL: rd_mux = {8'h00, counter_control_rd};
      capcmp_pkg::IDX_CAPTURE_EDGE_CONTROL: rd_mux = {8'h00, edge_control_rd};
      capcmp_pkg::IDX_CHAN0_CONTROL: rd_mux = {8'h00, chan_control_rd[0]};
      capcmp_pkg::IDX_CHAN1_CONTROL: rd_mux = {8'h00, chan_control_rd[1]};
      capcmp_pkg::IDX_CHAN0_RELOAD: rd_mux = state_r.reload[0];
      capcmp_pkg::IDX_CHAN1_RELOAD: rd_mux = state_r.reload[1];
      default: rd_mux = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.chan_evt = 2'h0;
    state_nxt.ovf_evt = 1'b0;
    state_nxt.pin_prev = pin_sampled;

    // read data stands in the cycle after the strobe only
    if (rd_i) begin
      state_nxt.rdata = rd_mux;
    end else begin
      state_nxt.rdata = 16'h0000;
    end

    // counter stepping
    if (tick) begin
      state_nxt.count = state_r.count + 16'h0001;
      if (state_r.count == capcmp_pkg::COUNT_MAX) begin
        state_nxt.ovf_evt = 1'b1; // RL20
      end
    end

    // software writes
    if (wr_i) begin
      unique case (addr_i)
        capcmp_pkg::IDX_COUNT: begin
          state_nxt.count = wdata_i; // RL15
        end
        capcmp_pkg::IDX_CHAN0_VALUE: begin
          state_nxt.value[0] = wdata_i; // RL1
        end
        capcmp_pkg::IDX_CHAN1_VALUE: begin
          state_nxt.value[1] = wdata_i; // RL1
        end
        capcmp_pkg::IDX_COUNTER_CONTROL: begin
          state_nxt.clk_sel = wdata_i[capcmp_pkg::POS_COUNT_CLOCK_SELECT +: 3]; // RL13
          state_nxt.run = wdata_i[capcmp_pkg::POS_COUNTER_RUN]; // RL13
          state_nxt.mode = wdata_i[capcmp_pkg::POS_CHAN0_MODE_SELECT +: 2]; // RL14
        end
        capcmp_pkg::IDX_CAPTURE_EDGE_CONTROL: begin
          state_nxt.edge_sel = wdata_i[capcmp_pkg::POS_CHAN0_EDGE_SELECT +: 4]; // RL7 RL8
        end
        capcmp_pkg::IDX_CHAN0_CONTROL: begin
          state_nxt.ctl[0] = wdata_i[2:0]; // RL6 RL16
        end
        capcmp_pkg::IDX_CHAN1_CONTROL: begin
          state_nxt.ctl[1] = wdata_i[2:0]; // RL6 RL16
        end
        capcmp_pkg::IDX_CHAN0_RELOAD: begin
          state_nxt.reload[0] = wdata_i; // RL12
        end
        capcmp_pkg::IDX_CHAN1_RELOAD: begin
          state_nxt.reload[1] = wdata_i; // RL12
        end
        default: begin
        end
      endcase
    end

    // channel events override software in the same cycle
    for (int c = 0; c < capcmp_pkg::NUM_CHAN; c++) begin
      if (state_r.mode[c]) begin
        if (state_r.run && edge_hit[c]) begin // RL3
          state_nxt.value[c] = state_r.count; // RL2
          state_nxt.chan_evt[c] = 1'b1; // RL2
        end
      end else if (match[c]) begin
        state_nxt.ctl[c][capcmp_pkg::POS_PIN_OUTPUT_BIT] =
          state_r.ctl[c][capcmp_pkg::POS_NEXT_LEVEL_BUFFER]; // RL4
        state_nxt.ctl[c][capcmp_pkg::POS_NEXT_LEVEL_BUFFER] =
          state_r.ctl[c][capcmp_pkg::POS_SECOND_LEVEL_BUFFER]; // RL4
        state_nxt.value[c] = state_r.reload[c]; // RL5
        state_nxt.chan_evt[c] = 1'b1; // RL19
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r.count <= capcmp_pkg::RST_COUNT;
      state_r.clk_sel <= capcmp_pkg::RST_COUNTER_CONTROL[2:0];
      state_r.run <= capcmp_pkg::RST_COUNTER_CONTROL[capcmp_pkg::POS_COUNTER_RUN];
      state_r.mode <= capcmp_pkg::RST_COUNTER_CONTROL[5:4];
      state_r.edge_sel <= capcmp_pkg::RST_CAPTURE_EDGE_CONTROL[5:2]; // RL8
      state_r.value <= {2{capcmp_pkg::RST_VALUE}}; // RL11
      state_r.reload <= {2{capcmp_pkg::RST_RELOAD}}; // RL12
      state_r.ctl <= {2{capcmp_pkg::RST_CHAN_CONTROL[2:0]}}; // RL6
      state_r.pin_prev <= 2'h0;
      state_r.chan_evt <= 2'h0;
      state_r.ovf_evt <= 1'b0;
      state_r.rdata <= 16'h0000;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < capcmp_pkg::NUM_CHAN; c++) begin
      channel_pin_o[c] = state_r.ctl[c][capcmp_pkg::POS_PIN_OUTPUT_BIT]; // RL16
    end
  end

  // pin driven in compare mode, released in capture mode
  assign channel_pin_oe_b_o = state_r.mode;
  assign chan_event_o = state_r.chan_evt;
  assign overflow_event_o = state_r.ovf_evt;
  assign rdata_o = state_r.rdata;

endmodule

// ==== dv/capcmp_timer_asserts.sv ====
// port-level assertion checker for the capture/compare timer
`timescale 1ns/1ns
module capcmp_timer_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [capcmp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [capcmp_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [capcmp_pkg::DATA_W-1:0] rdata_o,
  input wire logic [capcmp_pkg::TICK_W-1:0] count_tick_i,
  input wire logic [capcmp_pkg::NUM_CHAN-1:0] channel_pin_i,
  input wire logic [capcmp_pkg::NUM_CHAN-1:0] channel_pin_o,
  input wire logic [capcmp_pkg::NUM_CHAN-1:0] channel_pin_oe_b_o,
  input wire logic [capcmp_pkg::NUM_CHAN-1:0] chan_event_o,
  input wire logic overflow_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  chk_ctrl_ones: assert property (rd_i && (addr_i == 4'h5 || addr_i == 4'h6)
    |=> rdata_o[15:3] == 13'h001f) else $error("channel control fixed bits wrong");
  chk_edge_fixed: assert property (rd_i && addr_i == 4'h4
    |=> rdata_o[15:6] == 10'h003 && rdata_o[1:0] == 2'h0) else $error("edge control fixed bits");
  chk_reload_rw: assert property (wr_i && addr_i == 4'h7 ##1 rd_i && addr_i == 4'h7
    |=> rdata_o == $past(wdata_i, 2)) else $error("reload readback wrong");
  chk_ctrl_rw: assert property (wr_i && addr_i == 4'h5 && count_tick_i == 8'h00 ##1
    rd_i && addr_i == 4'h5 && count_tick_i == 8'h00
    |=> rdata_o[2:0] == $past(wdata_i[2:0], 2)) else $error("control readback wrong");
  chk_pin_follows: assert property (wr_i && addr_i == 4'h5 && count_tick_i == 8'h00
    |=> channel_pin_o[0] == $past(wdata_i[0])) else $error("pin not following level bit");
  chk_oe_follows: assert property (wr_i && addr_i == 4'h3
    |=> channel_pin_oe_b_o == $past(wdata_i[5:4])) else $error("pin enable not following mode");
  chk_ovf_tick: assert property (overflow_event_o |-> $past(count_tick_i) != 8'h00)
    else $error("overflow without a count tick");
endmodule

bind capcmp_timer capcmp_timer_asserts u_chk (.clk_i, .rst_b_i, .ce_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .count_tick_i, .channel_pin_i, .channel_pin_o, .channel_pin_oe_b_o,
  .chan_event_o, .overflow_event_o);

// ==== dv/capcmp_pin_source.sv ====
// far-side pulse source that drives the two capture pins
`timescale 1ns/1ns
module capcmp_pin_source (
  input wire logic clk_i,
  input wire logic [1:0] level_i,
  output logic [1:0] pin_o
);
  // levels change just after a rising edge and hold for whole clock periods
  always @(posedge clk_i) begin
    pin_o <= level_i;
  end
endmodule

// ==== dv/capcmp_timer_tb.sv ====
// self-checking bench for the capture/compare timer
`timescale 1ns/1ns
module capcmp_timer_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ce_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [7:0] count_tick_i = 8'h00;
  logic [1:0] level = 2'h0;
  logic [1:0] pin_in, pin_o, oe_b, ev;
  logic ovf;
  logic [15:0] rdata_o, d;
  logic [2:0] flags;
  int n_fail = 0;
  int checks = 0;
  int n_ev0 = 0;
  int n_ev1 = 0;
  int n_ovf = 0;
  int e0;
  assign flags = {ovf, ev};
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_ev0 += int'(ev[0] === 1'b1);
    n_ev1 += int'(ev[1] === 1'b1);
    n_ovf += int'(ovf === 1'b1);
  end
  capcmp_pin_source src (.clk_i(clk_i), .level_i(level), .pin_o(pin_in));
  capcmp_timer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_tick_i(count_tick_i),
    .channel_pin_i(pin_in), .channel_pin_o(pin_o), .channel_pin_oe_b_o(oe_b),
    .chan_event_o(ev), .overflow_event_o(ovf));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= v;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    op(1'b1, 1'b0, a, v);
    op(1'b0, 1'b0, a, v);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    op(1'b0, 1'b1, a, 16'h0000);
    op(1'b0, 1'b0, a, 16'h0000);
    #1;
    d = rdata_o;
  endtask
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] v);
    op(1'b1, 1'b0, a, v);
    rd(a);
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_hi(input int b);
    for (int k = 0; k < 200; k++) begin
      @(posedge clk_i);
      #1;
      if (flags[b] === 1'b1) break;
    end
    check("event wait", {15'h0000, flags[b]}, 16'h0001);
  endtask
  task automatic pulse(input logic [1:0] m);
    @(posedge clk_i);
    level <= m;
    repeat (4) @(posedge clk_i);
    level <= 2'h0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [15:0] rst_tab [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h00c0, 16'h00c0,
      16'h00f8, 16'h00f8, 16'h0000, 16'h0000, 16'h0000};
    logic [3:0] a_tab [11] = '{4'h5, 4'h5, 4'h6, 4'h4, 4'h4, 4'h7, 4'h8, 4'h2, 4'h9, 4'h0,
      4'h3};
    logic [15:0] w_tab [11] = '{16'hffff, 16'h0000, 16'hfffa, 16'hffff, 16'h0000,
      16'ha5c3, 16'h5a3c, 16'h2222, 16'hffff, 16'h4321, 16'hff37};
    logic [15:0] e_tab [11] = '{16'h00ff, 16'h00f8, 16'h00fa, 16'h00fc, 16'h00c0,
      16'ha5c3, 16'h5a3c, 16'h2222, 16'h0000, 16'h4321, 16'h00f7};
    for (int i = 0; i < 10; i++) begin
      rd(4'(i));
      check("reset value", d, rst_tab[i]);
    end
    for (int i = 0; i < 11; i++) begin
      wr_rd(a_tab[i], w_tab[i]);
      check("readback", d, e_tab[i]);
    end
    $display("register test done");
  endtask
  task automatic t_compare;
    wr(4'h1, 16'h0003);
    wr(4'h7, 16'h0020);
    wr(4'h0, 16'h0000);
    wr_rd(4'h5, 16'h0005);
    check("initial pin", {15'h0000, pin_o[0]}, 16'h0001);
    wr(4'h3, 16'h0008);
    check("pin driven", {14'h0000, oe_b}, 16'h0000);
    @(posedge clk_i);
    count_tick_i <= 8'h01;
    wait_hi(0);
    check("first match pin", {15'h0000, pin_o[0]}, 16'h0000);
    rd(4'h1);
    check("reloaded value", d, 16'h0020);
    rd(4'h5);
    check("buffers shifted", d, 16'h00fe);
    wait_hi(0);
    check("second match pin", {15'h0000, pin_o[0]}, 16'h0001);
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0020);
    repeat (20) @(posedge clk_i);
    check("match events", 16'(n_ev0), 16'h0002);
    rd(4'h0);
    check("halted count", d, 16'h0020);
    wr(4'h0, 16'hfffd);
    wr(4'h3, 16'h0008);
    wait_hi(2);
    @(posedge clk_i);
    count_tick_i <= 8'h00;
    rd(4'h0);
    check("overflow events", 16'(n_ovf), 16'h0001);
    check("count wrapped", {15'h0000, d < 16'h0010}, 16'h0001);
    $display("compare test done");
  endtask
  task automatic t_capture;
    wr(4'h3, 16'h0038);
    check("pins released", {14'h0000, oe_b}, 16'h0003);
    for (int c = 0; c < 4; c++) begin
      wr(4'h4, {12'h000, 2'(c), 2'h0});
      wr(4'h0, 16'h0100 + 16'(c));
      wr(4'h1, 16'hbeef);
      e0 = n_ev0;
      pulse(2'h1);
      check("capture events", 16'(n_ev0 - e0), 16'(c[0]) + 16'(c[1]));
      rd(4'h1);
      check("captured value", d, (c == 0) ? 16'hbeef : 16'h0100 + 16'(c));
    end
    wr(4'h4, 16'h0030);
    wr(4'h3, 16'h0030);
    wr(4'h2, 16'hbeef);
    pulse(2'h2);
    check("halted capture", 16'(n_ev1), 16'h0000);
    wr(4'h3, 16'h0038);
    wr(4'h0, 16'h0777);
    e0 = n_ev0;
    pulse(2'h2);
    check("chan1 events", 16'(n_ev1), 16'h0002);
    check("chan0 untouched", 16'(n_ev0 - e0), 16'h0000);
    rd(4'h2);
    check("chan1 value", d, 16'h0777);
    $display("capture test done");
  endtask
  task automatic t_freeze;
    wr(4'h3, 16'h0008);
    wr(4'h0, 16'h0200);
    @(posedge clk_i);
    ce_i <= 1'b0;
    count_tick_i <= 8'h01;
    repeat (10) @(posedge clk_i);
    ce_i <= 1'b1;
    count_tick_i <= 8'h00;
    rd(4'h0);
    check("frozen count", d, 16'h0200);
    $display("freeze test done");
  endtask
  task automatic t_reset;
    wr(4'h3, 16'h0030);
    wr(4'h5, 16'h0007);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h2);
    check("value after reset", d, 16'h0000);
    rd(4'h8);
    check("reload after reset", d, 16'h0000);
    rd(4'h3);
    check("counter control after reset", d, 16'h00c0);
    rd(4'h5);
    check("control after reset", d, 16'h00f8);
    check("pins after reset", {12'h000, oe_b, pin_o}, 16'h0000);
    $display("reset test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_compare;
    t_capture;
    t_freeze;
    t_reset;
    final_report;
  end
  initial begin
    #400000;
    n_fail++;
    final_report;
  end
endmodule
